/* File: hdl/mmd_indirect_access_portal.v */
// indirect access portal into the extended register space
// How it works
// - control bits 4:0 select the device that later accesses target
// - mode 00: writing the register/data register stores the target register address
// - other modes: register/data register reads or writes the addressed register's data
// - mode 01: data access leaves the stored address unchanged
// - mode 10: stored address increments after every read and every write
// - mode 11: stored address increments after writes only
// - register/data register is read/write and resets to zero
`timescale 1ns/1ps
`include "mmd_portal_defs.vh"
module mmd_indirect_access_portal #(
   parameter ADDR_W = 4
) (
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        wr_i,
   input  wire        rd_i,
   input  wire [4:0]  reg_sel_i,
   input  wire [15:0] wdata_i,
   output wire [15:0] rdata_o,
   output wire [15:0] ctrl_o,
   output wire [15:0] reg_addr_o
);

   // ==========================================================
   // sizes
   // device field width follows the control register layout
   localparam DEV_W = `CTRL_DEV_HI - `CTRL_DEV_LO + 1;

   // ==========================================================
   // decode functions
   function reg_hit;
      input [4:0] sel;
      input [4:0] offset;
      begin
         reg_hit = (sel == offset);
      end
   endfunction

   function is_data_mode;
      input [1:0] m;
      begin
         is_data_mode = (m != `MODE_ADDR);
      end
   endfunction

   function bumps_on_read;
      input [1:0] m;
      begin
         case (m)
            `MODE_DATA_INC_RW: bumps_on_read = 1'h1;
            `MODE_DATA_INC_WR: bumps_on_read = 1'h0;
            `MODE_DATA_NOINC:  bumps_on_read = 1'h0;
            default:           bumps_on_read = 1'h0;
         endcase
      end
   endfunction

   function bumps_on_write;
      input [1:0] m;
      begin
         case (m)
            `MODE_DATA_INC_RW: bumps_on_write = 1'h1;
            `MODE_DATA_INC_WR: bumps_on_write = 1'h1;
            `MODE_DATA_NOINC:  bumps_on_write = 1'h0;
            default:           bumps_on_write = 1'h0;
         endcase
      end
   endfunction

   // ==========================================================
   // state and decoded strobes
   reg  [15:0] ctrl_reg;
   reg  [15:0] ctrl_next;
   reg  [15:0] addr_reg;
   reg  [15:0] addr_next;
   reg  [15:0] rdata_reg;
   reg  [15:0] rdata_next;
   reg         bump_wr;
   reg         bump_rd;
   reg         bump;
   wire [1:0]  mode;
   wire [4:0]  dev;
   wire        hit_ctrl;
   wire        hit_portal;
   wire        ctrl_wr;
   wire        portal_wr;
   wire        portal_rd;
   wire        addr_load;
   wire        data_wr;
   wire        data_rd;
   wire [15:0] store_q;

   // ==========================================================
   // register select
   assign mode       = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
   assign dev        = ctrl_reg[`CTRL_DEV_HI:`CTRL_DEV_LO];
   assign hit_ctrl   = reg_hit(reg_sel_i, `CTRL_OFFSET);
   assign hit_portal = reg_hit(reg_sel_i, `REGDATA_OFFSET);

   // ==========================================================
   // write and read strobes
   // the mode decides whether a portal write is an address or data
   assign ctrl_wr    = wr_i & hit_ctrl;
   assign portal_wr  = wr_i & hit_portal;
   assign portal_rd  = rd_i & hit_portal;
   assign addr_load  = portal_wr & ~is_data_mode(mode);
   assign data_wr    = portal_wr & is_data_mode(mode);
   assign data_rd    = portal_rd & is_data_mode(mode);

   // ==========================================================
   // extended register store
   // only the low address bits index it, so higher addresses alias
   // contents survive a reset; only the portal registers clear
   mmd_data_store #(
      .DEV_W  (DEV_W),
      .ADDR_W (ADDR_W)
   ) u_store (
      .mclk_i  (mclk_i),
      .we_i    (data_wr),
      .dev_i   (dev),
      .addr_i  (addr_reg[ADDR_W-1:0]),
      .wdata_i (wdata_i),
      .rdata_o (store_q)
   );

   // ==========================================================
   // post increment
   // mode 00 raises neither data strobe, so no increment can follow
   always @* begin
      bump_wr = 1'h0;
      bump_rd = 1'h0;
      if (data_wr) begin
         bump_wr = bumps_on_write(mode);
      end
      if (data_rd) begin
         bump_rd = bumps_on_read(mode);
      end
      bump = bump_wr | bump_rd;
   end

   // ==========================================================
   // control register
   // reserved bits are kept as written; nothing inside decodes them
   always @* begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next = wdata_i;
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_reg <= `CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ==========================================================
   // register/data register, address half
   always @* begin
      addr_next = addr_reg;
      if (addr_load) begin
         addr_next = wdata_i;
      end else if (bump) begin
         // wraps at 16 bits, like the register it mirrors
         addr_next = addr_reg + 16'h0001;
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         addr_reg <= `REGDATA_RESET;
      end else begin
         addr_reg <= addr_next;
      end
   end

   // ==========================================================
   // read data
   // registered: the answer stands until the next read strobe
   always @* begin
      rdata_next = rdata_reg;
      if (rd_i) begin
         case (reg_sel_i)
            `CTRL_OFFSET: begin
               rdata_next = ctrl_reg;
            end
            `REGDATA_OFFSET: begin
               if (is_data_mode(mode)) begin
                  rdata_next = store_q;
               end else begin
                  rdata_next = addr_reg;
               end
            end
            default: begin
               rdata_next = `UNMAPPED_READ;
            end
         endcase
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_reg <= `RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // outputs
   // every output is a flop, so the host never sees decode glitches
   assign ctrl_o     = ctrl_reg;
   assign reg_addr_o = addr_reg;
   assign rdata_o    = rdata_reg;
endmodule

/* File: inc/mmd_portal_defs.vh */
// register offsets, field positions and reset values of the indirect access portal
`ifndef MMD_PORTAL_DEFS_VH
`define MMD_PORTAL_DEFS_VH
`define CTRL_OFFSET       5'h0D
`define REGDATA_OFFSET    5'h0E
`define CTRL_MODE_HI      15
`define CTRL_MODE_LO      14
`define CTRL_DEV_HI       4
`define CTRL_DEV_LO       0
`define CTRL_RESET        16'h0000
`define REGDATA_RESET     16'h0000
`define RDATA_RESET       16'h0000
`define UNMAPPED_READ     16'h0000
`define MODE_ADDR         2'h0
`define MODE_DATA_NOINC   2'h1
`define MODE_DATA_INC_RW  2'h2
`define MODE_DATA_INC_WR  2'h3
`endif

/* File: hdl/mmd_data_store.v */
// small memory of extended register words, indexed by device and register address
`timescale 1ns/1ps
module mmd_data_store #(
   parameter DEV_W  = 5,
   parameter ADDR_W = 4
) (
   input  wire              mclk_i,
   input  wire              we_i,
   input  wire [DEV_W-1:0]  dev_i,
   input  wire [ADDR_W-1:0] addr_i,
   input  wire [15:0]       wdata_i,
   output wire [15:0]       rdata_o
);
   reg [15:0] mem_reg [0:(1<<(DEV_W+ADDR_W))-1];

   // contents have no reset: software must write before it reads
   always @(posedge mclk_i) begin
      if (we_i) begin
         mem_reg[{dev_i, addr_i}] <= wdata_i;
      end
   end

   assign rdata_o = mem_reg[{dev_i, addr_i}];
endmodule

/* File: test/portal_chk.sv */
// assertions on the portal outputs
`timescale 1ns/1ps
module portal_chk (
   input wire        mclk_i,
   input wire        rst_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [4:0]  reg_sel_i,
   input wire [15:0] wdata_i,
   input wire [15:0] rdata_o,
   input wire [15:0] ctrl_o,
   input wire [15:0] reg_addr_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (rst_i);
wire [1:0] m = ctrl_o[15:14];
wire a = reg_sel_i == 5'h0E && (wr_i || rd_i);
sequence bump;
   reg_addr_o == $past(reg_addr_o) + 16'h1;
endsequence
chk_ctrl_write: assert property (wr_i && reg_sel_i == 5'h0D |=> ctrl_o == $past(wdata_i))
   else $error("ctrl lost");
chk_addr_load: assert property (a && wr_i && m == 2'h0 |=> reg_addr_o == $past(wdata_i))
   else $error("addr lost");
chk_addr_keep: assert property (a && (m == 2'h1 || rd_i && m != 2'h2) |=> $stable(reg_addr_o))
   else $error("addr moved");
chk_inc_rw: assert property (a && m == 2'h2 |=> bump)
   else $error("no inc");
chk_inc_wr: assert property (a && wr_i && m == 2'h3 |=> bump)
   else $error("no inc");
chk_idle_keep: assert property (!a |=> $stable(reg_addr_o))
   else $error("addr moved");
chk_addr_read: assert property (a && rd_i && m == 2'h0 |=> rdata_o == $past(reg_addr_o))
   else $error("bad addr read");
chk_ctrl_read: assert property (rd_i && reg_sel_i == 5'h0D |=> rdata_o == $past(ctrl_o))
   else $error("bad ctrl read");
chk_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
   else $error("rdata moved");
endmodule
bind mmd_indirect_access_portal portal_chk i_chk (.*);

/* File: test/mgmt_host.sv */
// management host model issuing portal accesses
`timescale 1ns/1ps
module mgmt_host (
   input  wire        mclk_i,
   output reg         wr_o = 1'h0,
   output reg         rd_o = 1'h0,
   output reg  [4:0]  sel_o = 5'h00,
   output reg  [15:0] wd_o = 16'h0000
);
// data line shows the inverse once released
task acc(input w, input [4:0] s, input [15:0] d);
   @(posedge mclk_i) #1 {wr_o, rd_o, sel_o, wd_o} = {w, !w, s, d};
   @(posedge mclk_i) #1 {wr_o, rd_o, wd_o} = {2'h0, ~d};
endtask
endmodule

/* File: test/mmd_indirect_access_portal_tb.sv */
// self-checking bench of the indirect access portal
`timescale 1ns/1ps
module mmd_indirect_access_portal_tb;
reg mclk_i = 0, rst_i = 1;
wire wr, rd;
wire [4:0] sel;
wire [15:0] wd, rdata_o, ctrl_o, reg_addr_o;
reg [15:0] lf = 16'h0006, v0, v1, q[$];
integer n_mismatch = 0, checked = 0;
initial forever #12.5 mclk_i = ~mclk_i;
mgmt_host i_mgmt_host (.mclk_i(mclk_i), .wr_o(wr), .rd_o(rd), .sel_o(sel), .wd_o(wd));
mmd_indirect_access_portal i_mmd_indirect_access_portal (.mclk_i(mclk_i), .rst_i(rst_i),
   .wr_i(wr), .rd_i(rd), .reg_sel_i(sel), .wdata_i(wd), .rdata_o(rdata_o), .ctrl_o(ctrl_o),
   .reg_addr_o(reg_addr_o));
function [15:0] nx(input [15:0] x);
   nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
endfunction
task cmp(input [15:0] s, e);
   checked = checked + 1;
   if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD rdata exp %h saw %h", e, s);
   end
endtask
task w(input [4:0] s, input [15:0] d); i_mgmt_host.acc(1'b1, s, d); endtask
task r(input [4:0] s, input [15:0] e); q.push_back(e); i_mgmt_host.acc(1'b0, s, 16'h0); endtask
task go(input [1:0] m, input [15:0] a);
   w(5'h0D, 16'h0002); w(5'h0E, a); w(5'h0D, {m, 14'h0002});
endtask
always @(posedge mclk_i) if (rd) #2 cmp(rdata_o, q.pop_front());
task final_report;
   $display("mismatches %0d checks %0d", n_mismatch, checked);
   if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
   else
      $display("DONE - FAIL");
   $finish;
endtask
initial begin
   repeat (12) @(posedge mclk_i);
   #1 rst_i = 0;
   r(5'h0E, 16'h0000);
   $display("test reset value ended");
   v0 = nx(lf); v1 = nx(v0);
   go(2'h1, 16'h0010); w(5'h0E, v0); r(5'h0E, v0); r(5'h0E, v0);
   $display("test mode 01 ended");
   go(2'h2, 16'h0011); w(5'h0E, v1); w(5'h0E, v0);
   go(2'h2, 16'h0011); r(5'h0E, v1); r(5'h0E, v0);
   $display("test mode 10 ended");
   go(2'h3, 16'h0013); w(5'h0E, v1); w(5'h0E, v0);
   go(2'h3, 16'h0013); r(5'h0E, v1); r(5'h0E, v1);
   $display("test mode 11 ended");
   w(5'h0D, 16'h0002); r(5'h0E, 16'h0013); r(5'h01, 16'h0000);
   $display("test mode 00 persistence ended");
   w(5'h0D, 16'h4003); w(5'h0E, ~v0); r(5'h0E, ~v0); r(5'h0D, 16'h4003);
   w(5'h0D, 16'h4002); r(5'h0E, v1);
   $display("test device select ended");
   final_report;
end
initial begin #100000; n_mismatch = n_mismatch + 1; final_report; end
endmodule
